// ---- common/erc_defines.vh ----
// Command codes, parameter fields, reset values and timing counts of the refresh controller
`ifndef ERC_DEFINES_VH
`define ERC_DEFINES_VH
`define ERC_CMD_DATA_STOP 8'h11
`define ERC_CMD_REFRESH 8'h12
`define ERC_CMD_AUTO_SEQ 8'h17
`define ERC_CMD_FRAME_RATE 8'h30
`define ERC_CMD_TEMP_READ 8'h40
`define ERC_CMD_SENSOR_CFG 8'h41
`define ERC_AUTO_CODE_BASIC 8'ha5
`define ERC_AUTO_CODE_SLEEP 8'ha7
`define ERC_FLAG_BIT 7
`define ERC_COMMON_SEL_BIT 0
`define ERC_DYN_RATE_BIT 3
`define ERC_RATE_MSB 2
`define ERC_SENSOR_EN_BIT 7
`define ERC_FRAME_RATE_RST 8'h02
`define ERC_REFRESH_RST 8'h00
`define ERC_SENSOR_CFG_RST 8'h00
`define ERC_STATUS_RST 8'h00
`define ERC_TEMP_RST 8'h00
`define ERC_CLK_MHZ 125
`define ERC_STEP_US 10
`define ERC_STEP_CYCLES (`ERC_STEP_US * `ERC_CLK_MHZ)
`endif

// ---- core/erc_command_control.v ----
// Command decoder for refresh, auto sequence, frame rate and temperature read
`timescale 1ns/1ps
`include "erc_defines.vh"
module erc_command_control #(
   parameter STEP_CYCLES = `ERC_STEP_CYCLES
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire cmd_valid,
   input wire cmd_is_data,
   input wire [7:0] cmd_byte,
   input wire rd_req,
   output reg [7:0] rd_data,
   output reg rd_valid,
   input wire frame_complete,
   input wire table_from_register_en,
   input wire [7:0] temperature_value,
   input wire power_done,
   input wire refresh_done,
   output wire busy_n,
   output reg power_on_step,
   output reg refresh_active,
   output reg power_off_step,
   output reg deep_sleep_step,
   output reg common_drive_select,
   output reg [2:0] frame_rate_sel,
   output reg dynamic_rate_en,
   output reg sensor_enable_bit
);
   localparam ST_IDLE = 3'd0;
   localparam ST_PON = 3'd1;
   localparam ST_REFRESH = 3'd2;
   localparam ST_POF = 3'd3;
   localparam ST_SLEEP = 3'd4;

   localparam SL_REFRESH = 2'd0;
   localparam SL_RATE = 2'd1;
   localparam SL_SENSOR = 2'd2;
   // Sized copy so the 3-bit rate field can be cut from it
   localparam [7:0] RATE_RST = `ERC_FRAME_RATE_RST;

   reg [2:0] state_reg;
   reg [7:0] last_cmd_reg;
   reg [1:0] rd_index_reg;
   reg auto_run_reg;
   reg auto_sleep_reg;
   reg [15:0] step_cnt_reg;
   reg frame_sync1_reg;
   reg frame_sync2_reg;
   reg [7:0] temp_sync1_reg;
   reg [7:0] temp_sync2_reg;
   reg [7:0] temp_latch_reg;
   reg [7:0] status_latch_reg;
   reg rate_live_reg;
   reg [7:0] temp_prev_reg;
   reg [7:0] temp_clean_reg;
   wire [7:0] store_rd;
   wire idle;
   wire param_wr;
   wire [1:0] param_slot;

   function cmd_gated;
      input [7:0] code;
      begin
         cmd_gated = (code == `ERC_CMD_DATA_STOP) || (code == `ERC_CMD_REFRESH) ||
            (code == `ERC_CMD_TEMP_READ);
      end
   endfunction

   function step_expired;
      input [15:0] count;
      begin
         step_expired = (count == STEP_CYCLES[15:0]);
      end
   endfunction

   function auto_code_ok;
      input [7:0] code;
      begin
         auto_code_ok = (code == `ERC_AUTO_CODE_BASIC) || (code == `ERC_AUTO_CODE_SLEEP);
      end
   endfunction

   function [7:0] read_byte;
      input [7:0] code;
      input [1:0] index;
      input [7:0] status;
      input [7:0] temp;
      begin
         if (code == `ERC_CMD_DATA_STOP) begin
            read_byte = status;
         end else if (code == `ERC_CMD_TEMP_READ && index == 2'd0) begin
            read_byte = temp;
         end else begin
            read_byte = 8'h00;
         end
      end
   endfunction

   assign idle = (state_reg == ST_IDLE);
   // Combinational from state so the host sees busy in the cycle it starts
   assign busy_n = idle;

   assign param_wr = cmd_valid && cmd_is_data &&
      (last_cmd_reg == `ERC_CMD_FRAME_RATE || last_cmd_reg == `ERC_CMD_SENSOR_CFG);
   assign param_slot = (last_cmd_reg == `ERC_CMD_FRAME_RATE) ? SL_RATE : SL_SENSOR;

   // Only the rate slot is read back; the sensor slot keeps its byte for later use
   erc_param_store #(
      .DEPTH(4),
      .AW(2)
   ) u_store (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .wr_en(param_wr),
      .wr_addr(param_slot),
      .wr_data(cmd_byte),
      .rd_addr(SL_RATE),
      .rd_data(store_rd)
   );

   // Pin-side inputs pass two flops before use
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         frame_sync1_reg <= 1'b0;
         frame_sync2_reg <= 1'b0;
         temp_sync1_reg <= `ERC_TEMP_RST;
         temp_sync2_reg <= `ERC_TEMP_RST;
      end else begin
         frame_sync1_reg <= frame_complete;
         frame_sync2_reg <= frame_sync1_reg;
         temp_sync1_reg <= temperature_value;
         temp_sync2_reg <= temp_sync1_reg;
      end
   end

   // A word on two flops alone can tear; take it only after two equal samples
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         temp_prev_reg <= `ERC_TEMP_RST;
         temp_clean_reg <= `ERC_TEMP_RST;
      end else begin
         temp_prev_reg <= temp_sync2_reg;
         if (temp_sync2_reg == temp_prev_reg) begin
            temp_clean_reg <= temp_prev_reg;
         end
      end
   end

   // Rate fields wait a cycle after reset so the store's cleared read port is not copied
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rate_live_reg <= 1'b0;
         frame_rate_sel <= RATE_RST[`ERC_RATE_MSB:0];
         dynamic_rate_en <= 1'b0;
      end else begin
         rate_live_reg <= 1'b1;
         if (rate_live_reg) begin
            frame_rate_sel <= store_rd[`ERC_RATE_MSB:0];
            dynamic_rate_en <= store_rd[`ERC_DYN_RATE_BIT];
         end
      end
   end

   // Decode, read answers and the sequencer share one process so state has one driver
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         last_cmd_reg <= 8'h00;
         rd_index_reg <= 2'd0;
         auto_run_reg <= 1'b0;
         auto_sleep_reg <= 1'b0;
         step_cnt_reg <= 16'h0000;
         status_latch_reg <= `ERC_STATUS_RST;
         temp_latch_reg <= `ERC_TEMP_RST;
         common_drive_select <= 1'b0;
         sensor_enable_bit <= 1'b1;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         power_on_step <= 1'b0;
         refresh_active <= 1'b0;
         power_off_step <= 1'b0;
         deep_sleep_step <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         if (cmd_valid && !cmd_is_data) begin
            // Busy-gated codes are dropped entirely, so a later parameter cannot act
            if (!cmd_gated(cmd_byte) || idle) begin
               last_cmd_reg <= cmd_byte;
               rd_index_reg <= 2'd0;
               if (cmd_byte == `ERC_CMD_DATA_STOP) begin
                  status_latch_reg <= {frame_sync2_reg, 7'h00};
                  if (frame_sync2_reg) begin
                     state_reg <= ST_REFRESH;
                     refresh_active <= 1'b1;
                  end
               end
               if (cmd_byte == `ERC_CMD_TEMP_READ) begin
                  temp_latch_reg <= sensor_enable_bit ? temp_clean_reg : 8'h00;
               end
            end else begin
               last_cmd_reg <= 8'h00;
            end
         end else if (cmd_valid && cmd_is_data) begin
            // Parameters act only on the command they follow
            case (last_cmd_reg)
               `ERC_CMD_REFRESH: begin
                  if (idle) begin
                     common_drive_select <= cmd_byte[`ERC_COMMON_SEL_BIT];
                     state_reg <= ST_REFRESH;
                     refresh_active <= 1'b1;
                  end
               end
               `ERC_CMD_AUTO_SEQ: begin
                  if (idle && table_from_register_en &&
                     auto_code_ok(cmd_byte)) begin
                     auto_run_reg <= 1'b1;
                     auto_sleep_reg <= (cmd_byte == `ERC_AUTO_CODE_SLEEP);
                     state_reg <= ST_PON;
                     power_on_step <= 1'b1;
                     step_cnt_reg <= 16'h0000;
                  end
               end
               `ERC_CMD_SENSOR_CFG: begin
                  sensor_enable_bit <= ~cmd_byte[`ERC_SENSOR_EN_BIT];
               end
               default: begin
               end
            endcase
         end

         // Reads answer from bytes latched when the command arrived
         if (rd_req) begin
            rd_valid <= 1'b1;
            // Saturate so a long read burst never returns the reading a second time
            if (rd_index_reg != 2'd3) begin
               rd_index_reg <= rd_index_reg + 2'd1;
            end
            rd_data <= read_byte(last_cmd_reg, rd_index_reg, status_latch_reg, temp_latch_reg);
         end

         // Step timers give up after a bounded wait so a dead supply cannot hang busy
         case (state_reg)
            ST_IDLE: begin
            end
            ST_PON: begin
               step_cnt_reg <= step_cnt_reg + 16'h0001;
               if (power_done || step_expired(step_cnt_reg)) begin
                  power_on_step <= 1'b0;
                  refresh_active <= 1'b1;
                  state_reg <= ST_REFRESH;
               end
            end
            ST_REFRESH: begin
               if (refresh_done) begin
                  refresh_active <= 1'b0;
                  step_cnt_reg <= 16'h0000;
                  if (auto_run_reg) begin
                     power_off_step <= 1'b1;
                     state_reg <= ST_POF;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_POF: begin
               step_cnt_reg <= step_cnt_reg + 16'h0001;
               if (power_done || step_expired(step_cnt_reg)) begin
                  power_off_step <= 1'b0;
                  auto_run_reg <= 1'b0;
                  if (auto_sleep_reg) begin
                     deep_sleep_step <= 1'b1;
                     state_reg <= ST_SLEEP;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_SLEEP: begin
               deep_sleep_step <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- core/erc_param_store.v ----
// Small register store holding the latched command parameter bytes
`timescale 1ns/1ps
`include "erc_defines.vh"
module erc_param_store #(
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:DEPTH-1];
   integer i;
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= 8'h00;
         end
         mem[1] <= `ERC_FRAME_RATE_RST;
         rd_data <= 8'h00;
      end else begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ---- tb/erc_command_control_sva.sv ----
// Port assertions for the command decoder
`timescale 1ns/1ps
module erc_chk (
   input wire sys_clk,
   input wire sys_rst,
   input wire cmd_valid,
   input wire cmd_is_data,
   input wire [7:0] cmd_byte,
   input wire rd_req,
   input wire [7:0] rd_data,
   input wire rd_valid,
   input wire frame_complete,
   input wire table_from_register_en,
   input wire refresh_done,
   input wire busy_n,
   input wire power_on_step,
   input wire refresh_active,
   input wire common_drive_select,
   input wire [2:0] frame_rate_sel,
   input wire dynamic_rate_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   reg [7:0] last_cmd_reg;
   reg [7:0] acc_cmd_reg;
   wire par_w = cmd_valid && cmd_is_data;
   wire gated_code = cmd_byte == 8'h11 || cmd_byte == 8'h12 || cmd_byte == 8'h40;
   // acc_cmd_reg keeps the accepted command only, so a code dropped while busy leaves nothing; last_cmd_reg takes every code
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         last_cmd_reg <= 8'h00;
         acc_cmd_reg <= 8'h00;
      end else if (cmd_valid && !cmd_is_data) begin
         last_cmd_reg <= cmd_byte;
         acc_cmd_reg <= (busy_n || !gated_code) ? cmd_byte : 8'h00;
      end
   end
   property p_rd; rd_req |=> rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("no read answer");
   property p_bits; rd_req && last_cmd_reg == 8'h11 |=> rd_data[6:0] == 7'h00; endproperty
   a_bits: assert property (p_bits) else $error("status low bits set");
   property p_stop; cmd_valid && !cmd_is_data && cmd_byte == 8'h11 && busy_n && frame_complete
      && $past(frame_complete) && $past(frame_complete, 2) |=> !busy_n; endproperty
   a_stop: assert property (p_stop) else $error("stop did not start refresh");
   property p_drf; par_w && acc_cmd_reg == 8'h12 && busy_n
      |=> !busy_n && refresh_active && common_drive_select == $past(cmd_byte[0]); endproperty
   a_drf: assert property (p_drf) else $error("refresh start wrong");
   property p_ign; par_w && last_cmd_reg == 8'h12 && !busy_n |=> $stable(common_drive_select);
   endproperty
   a_ign: assert property (p_ign) else $error("busy refresh not ignored");
   property p_hold; refresh_active && !refresh_done |=> !busy_n; endproperty
   a_hold: assert property (p_hold) else $error("busy dropped in refresh");
   property p_rate; par_w && last_cmd_reg == 8'h30 |=> ##2
      {dynamic_rate_en, frame_rate_sel} == $past(cmd_byte[3:0], 3); endproperty
   a_rate: assert property (p_rate) else $error("frame rate not taken");
   property p_gate; par_w && last_cmd_reg == 8'h17 && !table_from_register_en && busy_n
      |=> busy_n [*2]; endproperty
   a_gate: assert property (p_gate) else $error("auto ran without tables");
   property p_auto; par_w && last_cmd_reg == 8'h17 && table_from_register_en && busy_n
      && (cmd_byte == 8'ha5 || cmd_byte == 8'ha7) |-> ##[1:2] power_on_step; endproperty
   a_auto: assert property (p_auto) else $error("auto no power on");
endmodule
bind erc_command_control erc_chk chk_u (.*);

// ---- tb/erc_host_model.sv ----
// Host model sending command bytes and read strobes
`timescale 1ns/1ps
module erc_host_model (
   input wire sys_clk,
   output reg cmd_valid,
   output reg cmd_is_data,
   output reg [7:0] cmd_byte,
   output reg rd_req
);
   initial begin
      cmd_valid = 1'b0;
      cmd_is_data = 1'b0;
      cmd_byte = 8'h00;
      rd_req = 1'b0;
   end
   // Released byte shows its inverse, never the stale value
   task put(input [7:0] b, input d);
      begin
         @(negedge sys_clk);
         cmd_valid <= 1'b1;
         cmd_is_data <= d;
         cmd_byte <= b;
         @(negedge sys_clk);
         cmd_valid <= 1'b0;
         cmd_byte <= ~b;
      end
   endtask
   task get;
      begin
         @(negedge sys_clk);
         rd_req <= 1'b1;
         @(negedge sys_clk);
         rd_req <= 1'b0;
      end
   endtask
endmodule

// ---- tb/tb_epd_refresh_command_control.sv ----
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_epd_refresh_command_control;
   reg sys_clk = 1'b0;
   reg sys_rst = 1'b1, frame_complete = 1'b0, table_from_register_en = 1'b0;
   reg power_done = 1'b0, refresh_done = 1'b0;
   reg [7:0] temperature_value = 8'h00, v;
   reg [3:0] rcnt = 4'h0;
   wire [7:0] cmd_byte, rd_data;
   wire [2:0] frame_rate_sel;
   wire cmd_valid, cmd_is_data, rd_req, rd_valid, busy_n, power_on_step, refresh_active;
   wire power_off_step, deep_sleep_step, common_drive_select, dynamic_rate_en, sensor_enable_bit;
   integer err_total = 0, compares = 0, cyc = 0, sleeps = 0, pofs = 0, i, seed, r;
   reg [7:0] exp_q[$];
   erc_command_control #(.STEP_CYCLES(8)) dut_u (.*);
   erc_host_model host_u (.*);
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (err_total == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task wait_idle;
      begin
         r = 0;
         while (busy_n !== 1'b1 && r < 200) begin
            @(negedge sys_clk);
            r = r + 1;
         end
         chk(busy_n, 1'b1);
      end
   endtask
   // Analog side answers power steps at once and ends refresh after a few cycles
   always @(negedge sys_clk) begin
      power_done <= (power_on_step | power_off_step) & ~power_done;
      rcnt <= refresh_active ? rcnt + 4'h1 : 4'h0;
      refresh_done <= (rcnt == 4'h5);
      if (deep_sleep_step === 1'b1)
         sleeps = sleeps + 1;
      if (power_off_step === 1'b1)
         pofs = pofs + 1;
      if (rd_valid === 1'b1)
         chk(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         report_and_stop;
      end
   end
   initial begin
      seed = 32'h7a8e;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk({busy_n, dynamic_rate_en, sensor_enable_bit, frame_rate_sel}, 8'h2a);
      @(negedge sys_clk);
      chk(frame_rate_sel, 8'h02);
      for (i = 0; i < 8; i = i + 1) begin
         v = $random(seed);
         v[2:0] = i[2:0];
         host_u.put(8'h30, 1'b0);
         host_u.put(v, 1'b1);
         repeat (2) @(negedge sys_clk);
         chk({dynamic_rate_en, frame_rate_sel}, {4'h0, v[3:0]});
      end
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      @(negedge sys_clk);
      chk({dynamic_rate_en, frame_rate_sel}, 8'h02);
      for (i = 0; i < 2; i = i + 1) begin
         frame_complete = i[0];
         repeat (3) @(negedge sys_clk);
         host_u.put(8'h11, 1'b0);
         exp_q.push_back({i[0], 7'h00});
         host_u.get;
         chk(busy_n, !i[0]);
         wait_idle;
      end
      host_u.put(8'h12, 1'b0);
      host_u.put(8'h01, 1'b1);
      @(negedge sys_clk);
      chk({busy_n, refresh_active, common_drive_select}, 8'h03);
      host_u.put(8'h12, 1'b0);
      host_u.put(8'h00, 1'b1);
      wait_idle;
      chk(common_drive_select, 1'b1);
      r = {$random(seed)} % 86;
      temperature_value = r[7:0] - 8'd25;
      for (i = 0; i < 2; i = i + 1) begin
         repeat (3) @(negedge sys_clk);
         host_u.put(8'h40, 1'b0);
         exp_q.push_back(i ? 8'h00 : temperature_value);
         host_u.get;
         exp_q.push_back(8'h00);
         host_u.get;
         host_u.put(8'h41, 1'b0);
         host_u.put(8'h80, 1'b1);
      end
      host_u.put(8'h17, 1'b0);
      host_u.put(8'ha5, 1'b1);
      repeat (3) @(negedge sys_clk);
      chk({busy_n, sensor_enable_bit}, 8'h02);
      table_from_register_en = 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         host_u.put(8'h17, 1'b0);
         host_u.put(i ? 8'ha7 : 8'ha5, 1'b1);
         @(negedge sys_clk);
         chk(busy_n, 1'b0);
         wait_idle;
         chk(sleeps[7:0], i[7:0]);
         chk(pofs[7:0], i[7:0] + 8'h01);
      end
      report_and_stop;
   end
endmodule
